// File: dcic_pkg.sv
/*
 * dcic_pkg: register indices, field positions, reset values and encodings of
 * the dual channel input capture timer.
 * Assumes a 32-bit AXI4-Lite register bus; byte address = 4 * index.
 */
package dcic_pkg;
	localparam int AW = 12;
	localparam int CW = 16;
	localparam int NCH = 2;
	localparam int NPIN = 8;
	// register indices (byte address = 4 * index)
	localparam logic [9:0] IDX_RUN = 10'h137;
	localparam logic [9:0] IDX_MODE = 10'h138;
	localparam logic [9:0] IDX_CTRL0 = 10'h140;
	localparam logic [9:0] IDX_IOCFG0 = 10'h142;
	localparam logic [9:0] IDX_CNT0 = 10'h144;
	localparam logic [9:0] IDX_GR0 = 10'h148;
	localparam logic [9:0] IDX_STAT = 10'h150;
	localparam logic [9:0] IDX_MASK = 10'h151;
	// counter_run_control: run bits [1:0], select bits [3:2], [7:4] read one
	localparam logic [7:0] RUN_RESET = 8'hFC;
	localparam int RUN_SEL_POS = 2;
	localparam logic [7:0] RUN_FILL = 8'hF0;
	// timer_mode_reg: lockstep bit 0, [3:1] read one, buffer selects [7:4]
	localparam logic [7:0] MODE_RESET = 8'h0E;
	localparam int MODE_SYNC_POS = 0;
	localparam int MODE_BUF_POS = 4;
	localparam logic [7:0] MODE_FILL = 8'h0E;
	// channel_control_reg: [2:0] clock, [4:3] external edge, [7:5] clear source
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int CTRL_CLK_POS = 0;
	localparam int CTRL_EDG_POS = 3;
	localparam int CTRL_CLR_POS = 5;
	localparam logic [2:0] CLK_F1 = 3'h0;
	localparam logic [2:0] CLK_F2 = 3'h1;
	localparam logic [2:0] CLK_F4 = 3'h2;
	localparam logic [2:0] CLK_F8 = 3'h3;
	localparam logic [2:0] CLK_F32 = 3'h4;
	localparam logic [2:0] CLK_EXT = 3'h5;
	localparam logic [2:0] CLK_HSO = 3'h6;
	localparam logic [2:0] CLR_FREE = 3'h0;
	localparam logic [2:0] CLR_CAP_A = 3'h1;
	localparam logic [2:0] CLR_CAP_B = 3'h2;
	localparam logic [2:0] CLR_SYNC = 3'h3;
	localparam logic [2:0] CLR_CAP_C = 3'h5;
	localparam logic [2:0] CLR_CAP_D = 3'h6;
	// edge select encoding
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	// io config: pin j at [4j+3:4j] = {filter, edge[1:0], capture}; bit 16 osc
	localparam logic [16:0] IOCFG_RESET = 17'h00000;
	localparam int IOCFG_OSC_POS = 16;
	localparam int PRESC_W = 5;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [9:0] STAT_RESET = 10'h000;
endpackage : dcic_pkg

// File: dcic_top.sv
/*
 * dcic_top: two 16-bit up-counters with four capture registers each, AXI4-Lite
 * register slave and masked level interrupt.
 * Assumes pins and oscillator inputs are asynchronous to aclk; each is
 * synchronised by two flip-flops before use.
 */
// Local design decision: the AXI4-Lite interface to the registers.
// Functional notes
// RULE1: pin edge copies counter into paired register
// RULE2: capture enabled per pin register pair
// RULE3: channel 0 register A may use oscillator
// RULE4: clock from dividers, fast oscillator, external pin
// RULE5: counters count up, free run wraps
// RULE6: writing run bit one starts counting
// RULE7: writing zero stops only when select set
// RULE8: interrupt on every capture and overflow
// RULE9: pin A0 capture, io or external clock
// RULE10: counter read returns live count
// RULE11: lockstep write loads both counters
// RULE12: capture on rising, falling or both
// RULE13: clear counter on overflow or capture
// RULE14: filter accepts level after three samples
// RULE15: register C/D selectable as A/B buffer
// RULE16: buffered capture moves old A/B onward
// RULE17: lockstep sync clear clears both counters
// RULE18: software sets select bit for capture
// RULE19: capture sets register status flag
module dcic_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic [dcic_pkg::AW-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// write data channel
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response channel
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address channel
	input wire logic [dcic_pkg::AW-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// read data channel
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// pins: index ch*4+j, j = A,B,C,D; pin 0 doubles as external count clock
	input wire logic [dcic_pkg::NPIN-1:0] timer_io_pin,
	input wire logic low_speed_osc_trigger,
	input wire logic high_speed_osc_clock,
	// interrupt
	output logic irq
);
	logic [7:0] run_ctl;
	logic [7:0] mode_reg;
	logic [7:0] ctrl [dcic_pkg::NCH];
	logic [16:0] iocfg [dcic_pkg::NCH];
	logic [15:0] cnt [dcic_pkg::NCH];
	logic [15:0] gr [dcic_pkg::NPIN];
	logic [9:0] status;
	logic [9:0] mask;
	logic [dcic_pkg::NPIN-1:0] pin_s1, pin_s2, pin_h1, pin_h2, pin_filt, pin_prev;
	logic osc_s1, osc_s2, osc_prev, hso_s1, hso_s2, hso_prev;
	logic [dcic_pkg::PRESC_W-1:0] presc;
	logic [dcic_pkg::NPIN-1:0] cap;
	logic [dcic_pkg::NCH-1:0] tick, ovf, own_clr, clr, cnt_wr;
	logic aw_held, w_held;
	logic [9:0] w_idx;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [31:0] wmask;
	logic [9:0] r_idx;
	logic [31:0] next_rdata;
	logic w_hit, r_hit;

	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : strb_mask

	function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
		if (sel == dcic_pkg::EDGE_RISE)
			edge_hit = now & ~was;
		else if (sel == dcic_pkg::EDGE_FALL)
			edge_hit = ~now & was;
		else
			edge_hit = now ^ was;
	endfunction : edge_hit

	// write side: address and data taken independently, in either order
	assign awready = ~aw_held;
	assign wready = ~w_held;
	assign do_write = aw_held & w_held & ~bvalid;
	assign wmask = strb_mask(w_strb);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			w_idx <= 10'h000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				w_idx <= awaddr[dcic_pkg::AW-1:2];
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_comb begin
		// the gap between counters and general registers answers as unmapped, as on reads
		w_hit = (w_idx == dcic_pkg::IDX_RUN) || (w_idx == dcic_pkg::IDX_MODE) ||
			(w_idx >= dcic_pkg::IDX_CTRL0 && w_idx < dcic_pkg::IDX_CNT0 + 10'h002) ||
			(w_idx >= dcic_pkg::IDX_GR0 && w_idx < dcic_pkg::IDX_GR0 + 10'h008) ||
			(w_idx == dcic_pkg::IDX_STAT) || (w_idx == dcic_pkg::IDX_MASK);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= dcic_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= w_hit ? dcic_pkg::RESP_OKAY : dcic_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// control registers; reserved bits read back as ones
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_ctl <= dcic_pkg::RUN_RESET;
		end else if (do_write && w_idx == dcic_pkg::IDX_RUN && w_strb[0]) begin
			// a zero while select is clear is ignored: the count keeps running
			run_ctl[1:0] <= w_data[1:0] | (run_ctl[1:0] & ~run_ctl[3:2]); // RULE6 RULE7
			run_ctl[3:2] <= w_data[3:2]; // RULE18
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mode_reg <= dcic_pkg::MODE_RESET;
		else if (do_write && w_idx == dcic_pkg::IDX_MODE && w_strb[0])
			mode_reg <= (w_data[7:0] & 8'hF1) | dcic_pkg::MODE_FILL; // RULE15
	end

	// input synchronisers and three-sample filter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1 <= 8'h00;
			pin_s2 <= 8'h00;
			pin_h1 <= 8'h00;
			pin_h2 <= 8'h00;
			pin_filt <= 8'h00;
			pin_prev <= 8'h00;
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			osc_prev <= 1'b0;
			hso_s1 <= 1'b0;
			hso_s2 <= 1'b0;
			hso_prev <= 1'b0;
		end else begin
			pin_s1 <= timer_io_pin;
			pin_s2 <= pin_s1;
			pin_h1 <= pin_s2;
			pin_h2 <= pin_h1;
			for (int k = 0; k < dcic_pkg::NPIN; k++) begin
				if (pin_s2[k] == pin_h1[k] && pin_h1[k] == pin_h2[k])
					pin_filt[k] <= pin_h2[k]; // RULE14
				pin_prev[k] <= iocfg[k/4][(k%4)*4+3] ? pin_filt[k] : pin_s2[k];
			end
			osc_s1 <= low_speed_osc_trigger;
			osc_s2 <= osc_s1;
			osc_prev <= osc_s2;
			hso_s1 <= high_speed_osc_clock;
			hso_s2 <= hso_s1;
			hso_prev <= hso_s2;
		end
	end

	// capture events: per pin enable and edge choice
	always_comb begin
		logic lvl;
		logic [3:0] f;
		lvl = 1'b0;
		f = 4'h0;
		for (int k = 0; k < dcic_pkg::NPIN; k++) begin
			f = iocfg[k/4][(k%4)*4 +: 4];
			lvl = f[3] ? pin_filt[k] : pin_s2[k];
			cap[k] = f[0] & edge_hit(f[2:1], lvl, pin_prev[k]); // RULE2 RULE9 RULE12
		end
		if (iocfg[0][dcic_pkg::IOCFG_OSC_POS])
			cap[0] = iocfg[0][0] & edge_hit(iocfg[0][2:1], osc_s2, osc_prev); // RULE3
	end

	// prescaler for divided count sources
	always_ff @(posedge aclk) begin
		if (!aresetn)
			presc <= 5'h00;
		else
			presc <= presc + 5'h01;
	end

	generate
		for (genvar c = 0; c < dcic_pkg::NCH; c++) begin : g_ch
			localparam int O = 1 - c;
			logic [2:0] csrc;
			logic [2:0] cclr;
			logic src_tick;
			assign csrc = ctrl[c][dcic_pkg::CTRL_CLK_POS +: 3];
			assign cclr = ctrl[c][dcic_pkg::CTRL_CLR_POS +: 3];

			always_comb begin
				case (csrc) // RULE4
					dcic_pkg::CLK_F1: src_tick = 1'b1;
					dcic_pkg::CLK_F2: src_tick = (presc[0] == 1'b1);
					dcic_pkg::CLK_F4: src_tick = (presc[1:0] == 2'h3);
					dcic_pkg::CLK_F8: src_tick = (presc[2:0] == 3'h7);
					dcic_pkg::CLK_F32: src_tick = (presc == 5'h1F);
					dcic_pkg::CLK_EXT: src_tick = edge_hit(ctrl[c][dcic_pkg::CTRL_EDG_POS +: 2],
						pin_s2[0], pin_h1[0]); // RULE9
					dcic_pkg::CLK_HSO: src_tick = hso_s2 & ~hso_prev;
					default: src_tick = 1'b0;
				endcase
			end

			assign tick[c] = src_tick & run_ctl[c];
			assign ovf[c] = tick[c] && cnt[c] == dcic_pkg::CNT_MAX;
			assign own_clr[c] = (cclr == dcic_pkg::CLR_CAP_A && cap[c*4]) ||
				(cclr == dcic_pkg::CLR_CAP_B && cap[c*4+1]) ||
				(cclr == dcic_pkg::CLR_CAP_C && cap[c*4+2]) ||
				(cclr == dcic_pkg::CLR_CAP_D && cap[c*4+3]); // RULE13
			assign clr[c] = own_clr[c] || (mode_reg[dcic_pkg::MODE_SYNC_POS] &&
				cclr == dcic_pkg::CLR_SYNC && own_clr[O]); // RULE17
			assign cnt_wr[c] = do_write && w_strb[1:0] == 2'h3 &&
				(w_idx == dcic_pkg::IDX_CNT0 + 10'(c) ||
				(mode_reg[dcic_pkg::MODE_SYNC_POS] && w_idx == dcic_pkg::IDX_CNT0 + 10'(O))); // RULE11

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ctrl[c] <= dcic_pkg::CTRL_RESET;
					iocfg[c] <= dcic_pkg::IOCFG_RESET;
				end else if (do_write) begin
					if (w_idx == dcic_pkg::IDX_CTRL0 + 10'(c) && w_strb[0])
						ctrl[c] <= w_data[7:0];
					if (w_idx == dcic_pkg::IDX_IOCFG0 + 10'(c))
						iocfg[c] <= (iocfg[c] & ~wmask[16:0]) | (w_data[16:0] & wmask[16:0] &
							((c == 0) ? 17'h1FFFF : 17'h0FFFF));
				end
			end

			// overflow wraps to zero: clear-on-overflow is the free-running case
			always_ff @(posedge aclk) begin
				if (!aresetn)
					cnt[c] <= dcic_pkg::CNT_ZERO;
				else if (cnt_wr[c])
					cnt[c] <= w_data[15:0];
				else if (clr[c])
					cnt[c] <= dcic_pkg::CNT_ZERO; // RULE13 RULE17
				else if (tick[c])
					cnt[c] <= cnt[c] + 16'h0001; // RULE5
			end

			for (genvar j = 0; j < 2; j++) begin : g_pair
				localparam int P = c*4 + j;
				localparam int B = c*4 + j + 2;
				logic buf_on;
				assign buf_on = mode_reg[dcic_pkg::MODE_BUF_POS + c*2 + j];
				always_ff @(posedge aclk) begin
					if (!aresetn) begin
						gr[P] <= dcic_pkg::CNT_ZERO;
					end else if (cap[P]) begin
						gr[P] <= cnt[c]; // RULE1
					end else if (do_write && w_idx == dcic_pkg::IDX_GR0 + 10'(P) && w_strb[1:0] == 2'h3) begin
						gr[P] <= w_data[15:0];
					end
				end
				always_ff @(posedge aclk) begin
					if (!aresetn) begin
						gr[B] <= dcic_pkg::CNT_ZERO;
					end else if (buf_on && cap[P]) begin
						gr[B] <= gr[P]; // RULE15 RULE16
					end else if (!buf_on && cap[B]) begin
						gr[B] <= cnt[c]; // RULE1
					end else if (do_write && w_idx == dcic_pkg::IDX_GR0 + 10'(B) && w_strb[1:0] == 2'h3) begin
						gr[B] <= w_data[15:0];
					end
				end
			end
		end
	endgenerate

	// sticky events: a set in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= dcic_pkg::STAT_RESET;
		end else begin
			if (do_write && w_idx == dcic_pkg::IDX_STAT)
				status <= (status & ~(w_data[9:0] & wmask[9:0])) | {ovf, cap}; // RULE8 RULE19
			else
				status <= status | {ovf, cap}; // RULE8 RULE19
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mask <= dcic_pkg::STAT_RESET;
		else if (do_write && w_idx == dcic_pkg::IDX_MASK)
			mask <= (mask & ~wmask[9:0]) | (w_data[9:0] & wmask[9:0]);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(status & mask); // RULE8
	end

	// read side: one outstanding read, data registered
	assign arready = ~rvalid;
	assign r_idx = araddr[dcic_pkg::AW-1:2];

	always_comb begin
		next_rdata = 32'h00000000;
		r_hit = 1'b1;
		if (r_idx == dcic_pkg::IDX_RUN)
			next_rdata = {24'h000000, run_ctl | dcic_pkg::RUN_FILL};
		else if (r_idx == dcic_pkg::IDX_MODE)
			next_rdata = {24'h000000, mode_reg};
		else if (r_idx == dcic_pkg::IDX_CTRL0 || r_idx == dcic_pkg::IDX_CTRL0 + 10'h001)
			next_rdata = {24'h000000, ctrl[r_idx[0]]};
		else if (r_idx == dcic_pkg::IDX_IOCFG0 || r_idx == dcic_pkg::IDX_IOCFG0 + 10'h001)
			next_rdata = {15'h0000, iocfg[r_idx[0]]};
		else if (r_idx == dcic_pkg::IDX_CNT0 || r_idx == dcic_pkg::IDX_CNT0 + 10'h001)
			next_rdata = {16'h0000, cnt[r_idx[0]]}; // RULE10
		else if (r_idx >= dcic_pkg::IDX_GR0 && r_idx < dcic_pkg::IDX_GR0 + 10'h008)
			next_rdata = {16'h0000, gr[r_idx[2:0]]};
		else if (r_idx == dcic_pkg::IDX_STAT)
			next_rdata = {22'h000000, status};
		else if (r_idx == dcic_pkg::IDX_MASK)
			next_rdata = {22'h000000, mask};
		else
			r_hit = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= dcic_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= r_hit ? dcic_pkg::RESP_OKAY : dcic_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	a_capture_copy: assert property (@(posedge aclk) disable iff (!aresetn)
		cap[1] |=> gr[1] == $past(cnt[0])) else $error("capture did not copy counter"); // RULE1
	a_buffer_move: assert property (@(posedge aclk) disable iff (!aresetn)
		cap[0] && mode_reg[4] |=> gr[2] == $past(gr[0])) else $error("buffer not moved"); // RULE16
	a_count_up: assert property (@(posedge aclk) disable iff (!aresetn)
		tick[0] && !clr[0] && !cnt_wr[0] |=> cnt[0] == $past(cnt[0]) + 16'h0001) else $error("no increment"); // RULE5
	a_stopped_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!run_ctl[1] && !clr[1] && !cnt_wr[1] |=> $stable(cnt[1])) else $error("stopped counter moved"); // RULE6
	a_stop_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		run_ctl[0] && !run_ctl[2] |=> run_ctl[0]) else $error("run cleared without select"); // RULE7
	a_sync_load: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && w_idx == dcic_pkg::IDX_CNT0 && w_strb[1:0] == 2'h3 && mode_reg[0]
		|=> cnt[1] == $past(w_data[15:0])) else $error("lockstep load missed"); // RULE11
	a_clear_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		clr[0] && !cnt_wr[0] |=> cnt[0] == 16'h0000) else $error("counter not cleared"); // RULE13
	a_sync_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_reg[0] && ctrl[1][7:5] == 3'h3 && own_clr[0] |-> clr[1]) else $error("partner not cleared"); // RULE17
	a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		cap[2] |=> status[2]) else $error("capture flag not set"); // RULE19
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		ovf[0] && mask[8] |-> ##2 irq) else $error("overflow interrupt missing"); // RULE8
	a_filter_three: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(pin_filt[3]) |-> pin_h1[3] == pin_filt[3] && $past(pin_s2[3]) == pin_filt[3])
		else $error("filter accepted early"); // RULE14
endmodule : dcic_top

// File: dcic_pins_model.sv
/*
 * dcic_pins_model: far side of the capture timer: eight capture pins, the
 * slow oscillator trigger and the fast oscillator clock, as one line vector.
 * Assumes the bench calls its tasks right after a rising edge of aclk.
 */
module dcic_pins_model (
	// clock
	input wire logic aclk,
	// lines 0-7 pins, 8 slow osc, 9 fast osc
	output logic [9:0] lines
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		lines = 10'h000;
	end
	// level stays after the call, as a real pin would
	task automatic hold(input int idx, input logic lvl, input int cyc);
		lines[idx] <= lvl;
		repeat (cyc) @(posedge aclk);
	endtask : hold
	// width 4 so every edge survives the synchronisers
	task automatic pulses(input int idx, input int n);
		repeat (n) begin
			hold(idx, 1'b1, 4);
			hold(idx, 1'b0, 4);
		end
	endtask : pulses
endmodule : dcic_pins_model

// File: dcic_top_tb.sv
/*
 * dcic_top_tb: register level tests of the capture timer over AXI4-Lite.
 * Assumes dcic_pkg, dcic_top and dcic_pins_model are compiled first.
 */
module dcic_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk;
	logic aresetn;
	logic [dcic_pkg::AW-1:0] awaddr;
	logic [dcic_pkg::AW-1:0] araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] rv;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [1:0] rs;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq;
	logic [9:0] lines;
	logic [15:0] t;
	logic [15:0] dv;
	int err_count;
	int num_checks;
	dcic_top u_dcic_top (
		.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .timer_io_pin(lines[7:0]), .low_speed_osc_trigger(lines[8]),
		.high_speed_osc_clock(lines[9]), .irq
	);
	dcic_pins_model u_dcic_pins_model (.aclk, .lines);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	// whole run is about a thousand cycles
	initial begin
		#(25 * 20000);
		err_count++;
		summarize();
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk
	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] idx);
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic rc(input logic [9:0] idx, input logic [31:0] m, input logic [31:0] e, input string nm);
		rd(idx);
		chk(nm, e, rv & m);
	endtask : rc
	// difference of two back to back counter reads
	task automatic adv(input logic [9:0] idx);
		rd(idx);
		t = rv[15:0];
		rd(idx);
		dv = rv[15:0] - t;
	endtask : adv
	task automatic pin(input int i, input int n);
		u_dcic_pins_model.pulses(i, n);
	endtask : pin
	task automatic hl(input int i, input logic l, input int c);
		u_dcic_pins_model.hold(i, l, c);
	endtask : hl
	initial begin
		aresetn = 1'b0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		err_count = 0;
		num_checks = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rc(dcic_pkg::IDX_RUN, 32'hFF, 32'hFC, "run reset");
		rc(dcic_pkg::IDX_MODE, 32'hFF, 32'h0E, "mode reset");
		rd(10'h3FF);
		chk("unmapped read", 32'(dcic_pkg::RESP_SLVERR), 32'(rs));
		wr(10'h3FF, 32'h1);
		chk("unmapped write", 32'(dcic_pkg::RESP_SLVERR), 32'(rs));
		wr(dcic_pkg::IDX_MODE, 32'h1);
		wr(dcic_pkg::IDX_CNT0, 32'h1234);
		rc(dcic_pkg::IDX_CNT0 + 10'h1, 32'hFFFF, 32'h1234, "lockstep load");
		wr(dcic_pkg::IDX_MODE, 32'h0);
		wr(dcic_pkg::IDX_CNT0 + 10'h1, 32'h0055);
		rc(dcic_pkg::IDX_CNT0, 32'hFFFF, 32'h1234, "independent load");
		wr(dcic_pkg::IDX_RUN, 32'h0D);
		adv(dcic_pkg::IDX_CNT0);
		chk("count runs", 32'h1, 32'(dv inside {[16'h1:16'hA]}));
		wr(dcic_pkg::IDX_RUN, 32'h01);
		wr(dcic_pkg::IDX_RUN, 32'h00);
		adv(dcic_pkg::IDX_CNT0);
		chk("stop ignored", 32'h1, 32'(dv != 16'h0));
		// the stop write is judged against the select bits already held
		wr(dcic_pkg::IDX_RUN, 32'h0D);
		wr(dcic_pkg::IDX_RUN, 32'h0C);
		adv(dcic_pkg::IDX_CNT0);
		chk("count stopped", 32'h0, 32'(dv));
		wr(dcic_pkg::IDX_MASK, 32'h002);
		for (int k = 0; k < 3; k++) begin
			wr(dcic_pkg::IDX_IOCFG0, (2 * k + 1) * 16);
			wr(dcic_pkg::IDX_CNT0, 32'h1100 + k);
			hl(1, 1'b1, 8);
			wr(dcic_pkg::IDX_CNT0, 32'h2200 + k);
			hl(1, 1'b0, 8);
			rc(dcic_pkg::IDX_GR0 + 10'h1, 32'hFFFF, (k == 0) ? 32'h1100 : 32'h2200 + k, "edge capture");
			chk("irq set", 32'h1, 32'(irq));
			rc(dcic_pkg::IDX_STAT, 32'h3FF, 32'h002, "capture flag");
			wr(dcic_pkg::IDX_STAT, 32'h002);
			// irq is registered: it drops one edge after the flag clears
			@(posedge aclk);
			chk("irq clear", 32'h0, 32'(irq));
		end
		wr(dcic_pkg::IDX_IOCFG0, 32'h0100);
		pin(2, 1);
		pin(3, 1);
		rc(dcic_pkg::IDX_STAT, 32'h3FF, 32'h004, "per pin enable");
		chk("irq masked", 32'h0, 32'(irq));
		wr(dcic_pkg::IDX_MODE, 32'h10);
		wr(dcic_pkg::IDX_IOCFG0, 32'h1);
		wr(dcic_pkg::IDX_CNT0, 32'h0A0A);
		pin(0, 1);
		wr(dcic_pkg::IDX_CNT0, 32'h0B0B);
		pin(0, 1);
		rc(dcic_pkg::IDX_GR0, 32'hFFFF, 32'h0B0B, "buffered a");
		rc(dcic_pkg::IDX_GR0 + 10'h2, 32'hFFFF, 32'h0A0A, "buffer c");
		wr(dcic_pkg::IDX_MODE, 32'h0);
		wr(dcic_pkg::IDX_IOCFG0, 32'h10001);
		wr(dcic_pkg::IDX_CNT0, 32'h0C0C);
		pin(8, 1);
		rc(dcic_pkg::IDX_GR0, 32'hFFFF, 32'h0C0C, "osc capture");
		wr(dcic_pkg::IDX_IOCFG0, 32'h9);
		wr(dcic_pkg::IDX_CNT0, 32'h0D0D);
		hl(0, 1'b1, 1);
		hl(0, 1'b0, 10);
		rc(dcic_pkg::IDX_GR0, 32'hFFFF, 32'h0C0C, "glitch rejected");
		pin(0, 1);
		rc(dcic_pkg::IDX_GR0, 32'hFFFF, 32'h0D0D, "filtered capture");
		wr(dcic_pkg::IDX_STAT, 32'h3FF);
		wr(dcic_pkg::IDX_IOCFG0, 32'h0);
		for (int k = 0; k < 2; k++) begin
			wr(dcic_pkg::IDX_CTRL0, (k == 0) ? 32'(dcic_pkg::CLK_EXT) | (32'h2 << dcic_pkg::CTRL_EDG_POS) :
				32'(dcic_pkg::CLK_HSO));
			wr(dcic_pkg::IDX_CNT0, 32'h0);
			wr(dcic_pkg::IDX_RUN, 32'h0D);
			pin((k == 0) ? 0 : 9, 5);
			wr(dcic_pkg::IDX_RUN, 32'h0C);
			rc(dcic_pkg::IDX_CNT0, 32'hFFFF, (k == 0) ? 32'hA : 32'h5, "tick count");
		end
		// divided sources: 68 count edges between start and stop, phase unknown
		for (int k = 1; k < 5; k++) begin
			wr(dcic_pkg::IDX_CTRL0, 32'(k));
			wr(dcic_pkg::IDX_CNT0, 32'h0);
			wr(dcic_pkg::IDX_RUN, 32'h0D);
			repeat (64) @(posedge aclk);
			wr(dcic_pkg::IDX_RUN, 32'h0C);
			rd(dcic_pkg::IDX_CNT0);
			dv = 16'(68 / ((k == 4) ? 32 : (1 << k)));
			chk("divided count", 32'h1, 32'(rv[15:0] inside {[dv:dv + 16'h1]}));
		end
		wr(dcic_pkg::IDX_CTRL0, 32'(dcic_pkg::CLK_F1));
		wr(dcic_pkg::IDX_CNT0, 32'hFFF0);
		wr(dcic_pkg::IDX_MASK, 32'h100);
		wr(dcic_pkg::IDX_RUN, 32'h0D);
		repeat (40) @(posedge aclk);
		wr(dcic_pkg::IDX_RUN, 32'h0C);
		rc(dcic_pkg::IDX_CNT0, 32'hFF00, 32'h0, "wrap to zero");
		rc(dcic_pkg::IDX_STAT, 32'h3FF, 32'h100, "overflow flag");
		chk("overflow irq", 32'h1, 32'(irq));
		wr(dcic_pkg::IDX_STAT, 32'h3FF);
		wr(dcic_pkg::IDX_MODE, 32'h1);
		wr(dcic_pkg::IDX_CTRL0, 32'(dcic_pkg::CLR_CAP_A) << 5);
		wr(dcic_pkg::IDX_CTRL0 + 10'h1, 32'(dcic_pkg::CLR_SYNC) << 5);
		wr(dcic_pkg::IDX_IOCFG0, 32'h1);
		wr(dcic_pkg::IDX_CNT0, 32'h5000);
		wr(dcic_pkg::IDX_RUN, 32'h0F);
		pin(0, 1);
		wr(dcic_pkg::IDX_RUN, 32'h0C);
		rc(dcic_pkg::IDX_GR0, 32'hFF00, 32'h5000, "capture before clear");
		rc(dcic_pkg::IDX_CNT0, 32'hFF00, 32'h0, "clear on capture");
		rc(dcic_pkg::IDX_CNT0 + 10'h1, 32'hFF00, 32'h0, "sync clear");
		summarize();
	end
endmodule : dcic_top_tb
